//--- hw/pwg_defines.svh
/*
  Register offsets, field positions, reset values and timing counts of the
  generator. Assumes inclusion by bare name from files that need them.
*/
`ifndef PWG_DEFINES_SVH
`define PWG_DEFINES_SVH
`define PWG_OFF_CTRL 12'h000
`define PWG_OFF_PDUTY 12'h004
`define PWG_OFF_SDUTY 12'h008
`define PWG_OFF_LPER 12'h00C
`define PWG_OFF_STAT 12'h010
`define PWG_CTRL_WMASK 16'h1FEF
`define PWG_CTRL_RST 16'h0000
`define PWG_BIT_FLT_ST 15
`define PWG_BIT_CL_ST 14
`define PWG_BIT_TRG_ST 13
`define PWG_BIT_FLT_EN 12
`define PWG_BIT_CL_EN 11
`define PWG_BIT_TRG_EN 10
`define PWG_DT_COMP 2'h3
`define PWG_DT_OFF 2'h2
`define PWG_DT_NEG 2'h1
`define PWG_DT_POS 2'h0
`define PWG_MODE_COMPL 2'h0
`define PWG_MODE_REDUN 2'h1
`define PWG_MODE_PUSH 2'h2
`define PWG_MODE_INDEP 2'h3
`define PWG_MIN_PULSE 17'h00008
`define PWG_CAM_MASK 16'hFFF8
`define PWG_CLK_MHZ 25
`define PWG_EDGE_WIN_NS 40
`define PWG_EDGE_WIN_CYC ((`PWG_EDGE_WIN_NS * `PWG_CLK_MHZ) / 1000)
`define PWG_RESP_OK 2'h0
`define PWG_RESP_DECERR 2'h3
`endif

//--- hw/pwg_pkg.sv
/*
  Types of the PWM generator control block: control register layout and
  register selector. Assumes the defines header for numeric constants.
*/
package pwg_pkg;
  typedef struct packed {
    logic flt_st;
    logic cl_st;
    logic trg_st;
    logic flt_en;
    logic cl_en;
    logic trg_en;
    logic independent_period_select;
    logic shared_duty_select;
    logic [1:0] dead_time_control_field;
    logic compensation_polarity;
    logic unimpl;
    logic secondary_base_select;
    logic center_aligned_select;
    logic external_period_reset_enable;
    logic immediate_update_enable;
  } pwg_ctrl_t;

  typedef enum logic [2:0] {
    SEL_CTRL,
    SEL_PDUTY,
    SEL_SDUTY,
    SEL_LPER,
    SEL_STAT,
    SEL_NONE
  } pwg_sel_t;
endpackage

//--- hw/pwg_gen.sv
/*
  One PWM generator: control/duty registers behind an AXI4-Lite slave,
  local or master time base, duty compare, dead time and output steering.
  Assumes all inputs synchronous to CLK_SYS; master counts come from an
  external time base; event inputs are one-cycle pulses.
*/
// Chosen here: the register addresses and the AXI4-Lite slave port.
`timescale 1ns/1ps
`include "pwg_defines.svh"
module pwg_gen #(
  parameter bit SEC_TB_PRESENT = 1'b1
) (
  input wire logic CLK_SYS,
  input wire logic ARST_N,
  input wire logic [11:0] S_AXI_AWADDR,
  input wire logic S_AXI_AWVALID,
  output logic S_AXI_AWREADY,
  input wire logic [31:0] S_AXI_WDATA,
  input wire logic [3:0] S_AXI_WSTRB,
  input wire logic S_AXI_WVALID,
  output logic S_AXI_WREADY,
  output logic [1:0] S_AXI_BRESP,
  output logic S_AXI_BVALID,
  input wire logic S_AXI_BREADY,
  input wire logic [11:0] S_AXI_ARADDR,
  input wire logic S_AXI_ARVALID,
  output logic S_AXI_ARREADY,
  output logic [31:0] S_AXI_RDATA,
  output logic [1:0] S_AXI_RRESP,
  output logic S_AXI_RVALID,
  input wire logic S_AXI_RREADY,
  input wire logic [15:0] PRI_TB_COUNT,
  input wire logic [15:0] SEC_TB_COUNT,
  input wire logic [15:0] MASTER_PERIOD_VALUE,
  input wire logic [15:0] SHARED_DUTY_VALUE,
  input wire logic [1:0] OUT_MODE,
  input wire logic [13:0] DEAD_TIME,
  input wire logic COMPENSATION_INPUT,
  input wire logic FAULT_EVT,
  input wire logic CL_EVT,
  input wire logic TRIG_EVT,
  output logic HIGH_OUTPUT,
  output logic LOW_OUTPUT,
  output logic FAULT_IRQ,
  output logic CL_IRQ,
  output logic TRIG_IRQ
);

  function automatic pwg_pkg::pwg_sel_t reg_sel(input logic [11:0] addr);
    if (addr == `PWG_OFF_CTRL) return pwg_pkg::SEL_CTRL;
    else if (addr == `PWG_OFF_PDUTY) return pwg_pkg::SEL_PDUTY;
    else if (addr == `PWG_OFF_SDUTY) return pwg_pkg::SEL_SDUTY;
    else if (addr == `PWG_OFF_LPER) return pwg_pkg::SEL_LPER;
    else if (addr == `PWG_OFF_STAT) return pwg_pkg::SEL_STAT;
    else return pwg_pkg::SEL_NONE;
  endfunction

  function automatic logic [15:0] merge16(input logic [15:0] old, input logic [31:0] d,
                                          input logic [3:0] strb);
    logic [15:0] r;
    r = old;
    if (strb[0]) r[7:0] = d[7:0];
    if (strb[1]) r[15:8] = d[15:8];
    return r;
  endfunction

  pwg_pkg::pwg_ctrl_t ctrl_reg;
  logic [15:0] pduty_reg;
  logic [15:0] sduty_reg;
  logic [15:0] lper_reg;
  logic aw_full_reg;
  logic [11:0] aw_addr_reg;
  logic w_full_reg;
  logic [31:0] w_data_reg;
  logic [3:0] w_strb_reg;
  logic [15:0] cnt_reg;
  logic down_reg;
  logic pp_phase_reg;
  logic [15:0] act_h_reg;
  logic [15:0] act_l_reg;

  logic wr_do;
  pwg_pkg::pwg_sel_t wr_sel;
  pwg_pkg::pwg_ctrl_t wr_ctrl;
  assign wr_do = aw_full_reg & w_full_reg & ~S_AXI_BVALID;
  assign wr_sel = reg_sel(aw_addr_reg);
  assign wr_ctrl = pwg_pkg::pwg_ctrl_t'(merge16(ctrl_reg, w_data_reg, w_strb_reg));

  // write channel: address and data taken in either order, answer after both
  always_ff @(posedge CLK_SYS or negedge ARST_N) begin
    if (!ARST_N) begin
      S_AXI_AWREADY <= 1'b1;
      S_AXI_WREADY <= 1'b1;
      S_AXI_BVALID <= 1'b0;
      S_AXI_BRESP <= `PWG_RESP_OK;
      aw_full_reg <= 1'b0;
      aw_addr_reg <= 12'h000;
      w_full_reg <= 1'b0;
      w_data_reg <= 32'h0000_0000;
      w_strb_reg <= 4'h0;
    end else begin
      if (S_AXI_AWVALID && S_AXI_AWREADY) begin
        aw_full_reg <= 1'b1;
        aw_addr_reg <= S_AXI_AWADDR;
        S_AXI_AWREADY <= 1'b0;
      end
      if (S_AXI_WVALID && S_AXI_WREADY) begin
        w_full_reg <= 1'b1;
        w_data_reg <= S_AXI_WDATA;
        w_strb_reg <= S_AXI_WSTRB;
        S_AXI_WREADY <= 1'b0;
      end
      if (wr_do) begin
        aw_full_reg <= 1'b0;
        w_full_reg <= 1'b0;
        S_AXI_BVALID <= 1'b1;
        S_AXI_BRESP <= (wr_sel == pwg_pkg::SEL_NONE) ? `PWG_RESP_DECERR : `PWG_RESP_OK;
      end
      if (S_AXI_BVALID && S_AXI_BREADY) begin
        S_AXI_BVALID <= 1'b0;
        S_AXI_AWREADY <= 1'b1;
        S_AXI_WREADY <= 1'b1;
      end
    end
  end

  // set wins over the clear so an event landing on the disabling write is kept
  always_ff @(posedge CLK_SYS or negedge ARST_N) begin
    if (!ARST_N) begin
      ctrl_reg <= pwg_pkg::pwg_ctrl_t'(`PWG_CTRL_RST);
    end else begin
      if (wr_do && wr_sel == pwg_pkg::SEL_CTRL) begin
        ctrl_reg <= pwg_pkg::pwg_ctrl_t'((wr_ctrl & `PWG_CTRL_WMASK) |
                                         (ctrl_reg & ~`PWG_CTRL_WMASK));
        if (!wr_ctrl.flt_en) ctrl_reg.flt_st <= 1'b0;
        if (!wr_ctrl.cl_en) ctrl_reg.cl_st <= 1'b0;
        if (!wr_ctrl.trg_en) ctrl_reg.trg_st <= 1'b0;
        ctrl_reg.unimpl <= 1'b0;
      end
      if (FAULT_EVT) ctrl_reg.flt_st <= 1'b1;
      if (CL_EVT) ctrl_reg.cl_st <= 1'b1;
      if (TRIG_EVT) ctrl_reg.trg_st <= 1'b1;
    end
  end

  always_ff @(posedge CLK_SYS or negedge ARST_N) begin
    if (!ARST_N) begin
      pduty_reg <= 16'h0000;
      sduty_reg <= 16'h0000;
      lper_reg <= 16'h0000;
    end else if (wr_do) begin
      if (wr_sel == pwg_pkg::SEL_PDUTY) pduty_reg <= merge16(pduty_reg, w_data_reg, w_strb_reg);
      else if (wr_sel == pwg_pkg::SEL_SDUTY) sduty_reg <= merge16(sduty_reg, w_data_reg, w_strb_reg);
      else if (wr_sel == pwg_pkg::SEL_LPER) lper_reg <= merge16(lper_reg, w_data_reg, w_strb_reg);
    end
  end

  // interrupt requests: one-cycle pulse per event while its enable is set
  always_ff @(posedge CLK_SYS or negedge ARST_N) begin
    if (!ARST_N) begin
      FAULT_IRQ <= 1'b0;
      CL_IRQ <= 1'b0;
      TRIG_IRQ <= 1'b0;
    end else begin
      FAULT_IRQ <= FAULT_EVT & ctrl_reg.flt_en;
      CL_IRQ <= CL_EVT & ctrl_reg.cl_en;
      TRIG_IRQ <= TRIG_EVT & ctrl_reg.trg_en;
    end
  end

  // time base selection
  logic center;
  logic [15:0] lmask;
  logic [15:0] period;
  logic [15:0] master_cnt;
  logic [15:0] cnt;
  logic per_start;
  logic ext_rst;
  assign center = ctrl_reg.independent_period_select & ctrl_reg.center_aligned_select;
  assign lmask = center ? `PWG_CAM_MASK : 16'hFFFF;
  assign master_cnt = (ctrl_reg.secondary_base_select && SEC_TB_PRESENT) ? SEC_TB_COUNT : PRI_TB_COUNT;
  assign period = ctrl_reg.independent_period_select ? (lper_reg & lmask) : MASTER_PERIOD_VALUE;
  assign cnt = ctrl_reg.independent_period_select ? cnt_reg : master_cnt;
  assign per_start = (cnt == 16'h0000);
  // only the local base is restarted; the master count belongs to the shared base
  assign ext_rst = ctrl_reg.independent_period_select & ctrl_reg.external_period_reset_enable & CL_EVT;

  // local counter; in center mode it runs up to the period and back down
  // an edge-aligned local period spans the period value plus one clocks,
  // so software writes one less than the wanted length
  always_ff @(posedge CLK_SYS or negedge ARST_N) begin
    if (!ARST_N) begin
      cnt_reg <= 16'h0000;
      down_reg <= 1'b0;
    end else if (!ctrl_reg.independent_period_select || ext_rst) begin
      cnt_reg <= 16'h0000;
      down_reg <= 1'b0;
    end else if (center) begin
      if (!down_reg) begin
        if (cnt_reg >= period) down_reg <= 1'b1;
        else cnt_reg <= cnt_reg + 16'h0001;
      end else begin
        if (cnt_reg == 16'h0000) down_reg <= 1'b0;
        else cnt_reg <= cnt_reg - 16'h0001;
      end
    end else begin
      down_reg <= 1'b0;
      cnt_reg <= (cnt_reg >= period) ? 16'h0000 : cnt_reg + 16'h0001;
    end
  end

  // duty source and limits
  logic [15:0] src_h;
  logic [15:0] src_l;
  assign src_h = ctrl_reg.shared_duty_select ? SHARED_DUTY_VALUE : pduty_reg;
  assign src_l = ctrl_reg.shared_duty_select ? SHARED_DUTY_VALUE : sduty_reg;

  // below the shortest pulse gives no pulse, beyond the longest gives full on
  function automatic logic [16:0] limit_duty(input logic [15:0] d, input logic [15:0] p,
                                             input logic [15:0] m);
    logic [16:0] dm;
    logic [16:0] win;
    dm = {1'b0, d & m};
    win = 17'(`PWG_EDGE_WIN_CYC) << 3;
    if (dm < win || dm + win > {1'b0, p}) dm = {dm[16:3], 3'b000};
    if (dm < `PWG_MIN_PULSE) return 17'h00000;
    if (dm + `PWG_MIN_PULSE > {1'b0, p}) return {1'b0, p} + 17'h00001;
    return dm;
  endfunction

  // dead-time shifts saturate at the period end
  function automatic logic [16:0] sat_add(input logic [16:0] a, input logic [16:0] b,
                                          input logic [15:0] p);
    if (a + b > {1'b0, p}) return {1'b0, p};
    return a + b;
  endfunction

  // and at zero, so a short duty never wraps to a long one
  function automatic logic [16:0] sat_sub(input logic [16:0] a, input logic [16:0] b);
    if (a > b) return a - b;
    return 17'h00000;
  endfunction

  // active duty copies: immediate or reloaded at the start of each period
  always_ff @(posedge CLK_SYS or negedge ARST_N) begin
    if (!ARST_N) begin
      act_h_reg <= 16'h0000;
      act_l_reg <= 16'h0000;
    end else if (ctrl_reg.immediate_update_enable || per_start) begin
      act_h_reg <= src_h;
      act_l_reg <= src_l;
    end
  end

  // push-pull hands the pulse to the other output once per period
  always_ff @(posedge CLK_SYS or negedge ARST_N) begin
    if (!ARST_N) pp_phase_reg <= 1'b0;
    else if (per_start && !down_reg) pp_phase_reg <= ~pp_phase_reg;
  end

  // compare and dead time
  logic [16:0] dh;
  logic [16:0] dl;
  logic [16:0] dt;
  logic [16:0] c;
  logic indep;
  logic raw_h;
  logic raw_l;
  logic h_next;
  logic l_next;
  assign indep = (OUT_MODE == `PWG_MODE_INDEP);
  assign c = {1'b0, cnt};

  always_comb begin
    dt = {3'b000, DEAD_TIME} & {1'b1, lmask};
    dh = limit_duty(act_h_reg, period, lmask);
    dl = indep ? limit_duty(act_l_reg, period, lmask) : dh;
    raw_h = 1'b0;
    raw_l = 1'b0;
    case (ctrl_reg.dead_time_control_field)
      `PWG_DT_COMP: begin
        // polarity with the input level picks which side gains the dead time
        if (ctrl_reg.compensation_polarity ^ COMPENSATION_INPUT) begin
          dh = sat_add(dh, dt, period);
          // a paired low runs from its edge to the period end: a later edge shortens it
          dl = indep ? sat_sub(dl, dt) : sat_add(dl, dt, period);
        end else begin
          dh = sat_sub(dh, dt);
          dl = indep ? sat_add(dl, dt, period) : sat_sub(dl, dt);
        end
        raw_h = c < dh;
        raw_l = indep ? (c < dl) : (c >= dl);
      end
      `PWG_DT_OFF: begin
        raw_h = c < dh;
        raw_l = indep ? (c < dl) : (c >= dl);
      end
      `PWG_DT_NEG: begin
        // overlap only makes sense for complementary pairs
        if (OUT_MODE == `PWG_MODE_COMPL) begin
          raw_h = c < dh + dt;
          raw_l = (c + dt >= dl);
        end else begin
          raw_h = c < dh;
          raw_l = indep ? (c < dl) : (c >= dl);
        end
      end
      default: begin
        raw_h = (c >= dt) && (c < dh);
        raw_l = indep ? ((c >= dt) && (c < dl)) : (c >= dl + dt);
      end
    endcase
    case (OUT_MODE)
      `PWG_MODE_COMPL: begin
        h_next = raw_h;
        l_next = raw_l;
      end
      `PWG_MODE_REDUN: begin
        h_next = raw_h;
        l_next = raw_h;
      end
      `PWG_MODE_PUSH: begin
        h_next = raw_h & ~pp_phase_reg;
        l_next = raw_h & pp_phase_reg;
      end
      default: begin
        h_next = raw_h;
        l_next = raw_l;
      end
    endcase
  end

  always_ff @(posedge CLK_SYS or negedge ARST_N) begin
    if (!ARST_N) begin
      HIGH_OUTPUT <= 1'b0;
      LOW_OUTPUT <= 1'b0;
    end else begin
      HIGH_OUTPUT <= h_next;
      LOW_OUTPUT <= l_next;
    end
  end

  // read channel: one answer per address, data one cycle after the handshake
  logic [15:0] rd_val;
  pwg_pkg::pwg_sel_t rd_sel;
  // the status word is the selected count, so software can see period restarts
  assign rd_sel = reg_sel(S_AXI_ARADDR);
  always_comb begin
    if (rd_sel == pwg_pkg::SEL_CTRL) rd_val = ctrl_reg & 16'hFFEF;
    else if (rd_sel == pwg_pkg::SEL_PDUTY) rd_val = pduty_reg;
    else if (rd_sel == pwg_pkg::SEL_SDUTY) rd_val = sduty_reg;
    else if (rd_sel == pwg_pkg::SEL_LPER) rd_val = lper_reg;
    else if (rd_sel == pwg_pkg::SEL_STAT) rd_val = cnt;
    else rd_val = 16'h0000;
  end

  always_ff @(posedge CLK_SYS or negedge ARST_N) begin
    if (!ARST_N) begin
      S_AXI_ARREADY <= 1'b1;
      S_AXI_RVALID <= 1'b0;
      S_AXI_RDATA <= 32'h0000_0000;
      S_AXI_RRESP <= `PWG_RESP_OK;
    end else if (S_AXI_ARVALID && S_AXI_ARREADY) begin
      S_AXI_ARREADY <= 1'b0;
      S_AXI_RVALID <= 1'b1;
      S_AXI_RDATA <= {16'h0000, rd_val};
      S_AXI_RRESP <= (rd_sel == pwg_pkg::SEL_NONE) ? `PWG_RESP_DECERR : `PWG_RESP_OK;
    end else if (S_AXI_RVALID && S_AXI_RREADY) begin
      S_AXI_RVALID <= 1'b0;
      S_AXI_ARREADY <= 1'b1;
    end
  end

endmodule // pwg_gen

//--- verification/pwg_checker.sv
/*
  Port-level assertions for the PWM generator.
  Assumes bind into pwg_gen and a single CLK_SYS domain.
*/
`timescale 1ns/1ps
`include "pwg_defines.svh"
module pwg_checker (
  input wire logic CLK_SYS,
  input wire logic ARST_N,
  input wire logic S_AXI_AWVALID,
  input wire logic S_AXI_AWREADY,
  input wire logic S_AXI_WVALID,
  input wire logic S_AXI_WREADY,
  input wire logic S_AXI_BVALID,
  input wire logic S_AXI_BREADY,
  input wire logic [11:0] S_AXI_ARADDR,
  input wire logic S_AXI_ARVALID,
  input wire logic S_AXI_ARREADY,
  input wire logic [31:0] S_AXI_RDATA,
  input wire logic [1:0] S_AXI_RRESP,
  input wire logic S_AXI_RVALID,
  input wire logic S_AXI_RREADY,
  input wire logic FAULT_EVT,
  input wire logic CL_EVT,
  input wire logic TRIG_EVT,
  input wire logic FAULT_IRQ,
  input wire logic CL_IRQ,
  input wire logic TRIG_IRQ
);
  default clocking cb @(posedge CLK_SYS); endclocking
  default disable iff (!ARST_N);
  sequence s_wtake;
    S_AXI_AWVALID && S_AXI_AWREADY && S_AXI_WVALID && S_AXI_WREADY;
  endsequence
  sequence s_rtake;
    S_AXI_ARVALID && S_AXI_ARREADY;
  endsequence
  AST_WR_ANSWER: assert property (s_wtake |-> ##[1:2] S_AXI_BVALID)
    else $error("write response missing");
  AST_B_DONE: assert property (S_AXI_BVALID && S_AXI_BREADY |=> !S_AXI_BVALID)
    else $error("write response held after handshake");
  AST_R_DONE: assert property (S_AXI_RVALID && S_AXI_RREADY |=> !S_AXI_RVALID)
    else $error("read response held after handshake");
  AST_R_UPPER: assert property (S_AXI_RVALID |-> S_AXI_RDATA[31:16] == 16'h0000)
    else $error("read data upper half not zero");
  AST_CTRL_B4: assert property (s_rtake ##0 S_AXI_ARADDR == `PWG_OFF_CTRL
    |=> S_AXI_RVALID && !S_AXI_RDATA[4]) else $error("control bit 4 reads one");
  AST_UNMAPPED: assert property (s_rtake ##0 S_AXI_ARADDR > `PWG_OFF_STAT
    |=> S_AXI_RRESP == `PWG_RESP_DECERR && S_AXI_RDATA == 32'h00000000)
    else $error("unmapped read not refused");
  AST_FLT_IRQ: assert property (FAULT_IRQ |-> $past(FAULT_EVT))
    else $error("fault request without event");
  AST_CL_IRQ: assert property (CL_IRQ |-> $past(CL_EVT))
    else $error("current-limit request without event");
  AST_TRG_IRQ: assert property (TRIG_IRQ |-> $past(TRIG_EVT))
    else $error("trigger request without event");
endmodule // pwg_checker
bind pwg_gen pwg_checker u_chk (.*);

//--- verification/pwg_stage.sv
/*
  Power stage stand-in: counts cycles each output is on while gate is high.
  Assumes outputs settle between clock edges.
*/
`timescale 1ns/1ps
module pwg_stage (
  input wire logic clk,
  input wire logic high_in,
  input wire logic low_in,
  input wire logic gate,
  output logic [15:0] high_cnt,
  output logic [15:0] low_cnt
);
  // counts restart whenever gate drops, so one window never leaks into the next
  always @(posedge clk) begin
    high_cnt <= gate ? high_cnt + {15'h0000, high_in} : 16'h0000;
    low_cnt <= gate ? low_cnt + {15'h0000, low_in} : 16'h0000;
  end
endmodule // pwg_stage

//--- verification/tb_top.sv
/*
  Self-checking bench for pwg_gen: AXI4-Lite register access, events and
  duty measurement over whole periods. Assumes a 64-count primary base.
*/
`timescale 1ns/1ps
`include "pwg_defines.svh"
module tb_top;
  localparam logic [11:0] RC = `PWG_OFF_CTRL;
  localparam logic [11:0] RP = `PWG_OFF_PDUTY;
  localparam logic [11:0] RS = `PWG_OFF_SDUTY;
  localparam logic [1:0] OK = `PWG_RESP_OK;
  localparam logic [15:0] DV [3] = '{16'h0004, 16'h0010, 16'h003C};
  localparam logic [15:0] HV [3] = '{16'h0000, 16'h0010, 16'h0038};
  localparam logic [15:0] CW [6] = '{16'h0081, 16'h00A1, 16'h00E1, 16'h00E1, 16'h0001,
    16'h0041};
  localparam logic [15:0] CH [6] = '{16'h0010, 16'h0010, 16'h0012, 16'h000E, 16'h000E,
    16'h0012};
  localparam logic [15:0] CL [6] = '{16'h0030, 16'h0030, 16'h002E, 16'h0032, 16'h002E,
    16'h0032};
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic [11:0] awaddr = 12'h000, araddr = 12'h000;
  logic awv = 1'b0, wv = 1'b0, bready = 1'b0, arv = 1'b0, rready = 1'b0;
  logic [31:0] wdata = 32'h00000000;
  logic [15:0] pri = 16'h0000, sec = 16'h0000, shd = 16'h0000;
  logic [1:0] mode = 2'h3;
  logic [13:0] dt = 14'h0002;
  logic cin = 1'b0, gate = 1'b0;
  logic [2:0] evt = 3'h0;
  logic awrdy, wrdy, bvalid, arrdy, rvalid, hi, lo;
  logic [1:0] bresp, rresp;
  logic [31:0] rdata;
  logic [2:0] irq;
  logic [15:0] hcnt, lcnt;
  int err_count = 0;
  int checks_done = 0;
  always #20 clk = ~clk;
  // primary base runs 64 counts, secondary 32 so the two bases are told apart
  always @(posedge clk) begin
    pri <= (pri == 16'h003F) ? 16'h0000 : pri + 16'h0001;
    sec <= (sec == 16'h001F) ? 16'h0000 : sec + 16'h0001;
  end
  pwg_gen dut (.CLK_SYS(clk), .ARST_N(rst_n), .S_AXI_AWADDR(awaddr), .S_AXI_AWVALID(awv),
    .S_AXI_AWREADY(awrdy), .S_AXI_WDATA(wdata), .S_AXI_WSTRB(4'h3), .S_AXI_WVALID(wv),
    .S_AXI_WREADY(wrdy), .S_AXI_BRESP(bresp), .S_AXI_BVALID(bvalid), .S_AXI_BREADY(bready),
    .S_AXI_ARADDR(araddr), .S_AXI_ARVALID(arv), .S_AXI_ARREADY(arrdy), .S_AXI_RDATA(rdata),
    .S_AXI_RRESP(rresp), .S_AXI_RVALID(rvalid), .S_AXI_RREADY(rready), .PRI_TB_COUNT(pri),
    .SEC_TB_COUNT(sec), .MASTER_PERIOD_VALUE(16'h0040), .SHARED_DUTY_VALUE(shd),
    .OUT_MODE(mode), .DEAD_TIME(dt), .COMPENSATION_INPUT(cin), .FAULT_EVT(evt[2]),
    .CL_EVT(evt[1]), .TRIG_EVT(evt[0]), .HIGH_OUTPUT(hi), .LOW_OUTPUT(lo),
    .FAULT_IRQ(irq[2]), .CL_IRQ(irq[1]), .TRIG_IRQ(irq[0]));
  pwg_stage stage (.clk(clk), .high_in(hi), .low_in(lo), .gate(gate), .high_cnt(hcnt),
    .low_cnt(lcnt));
  task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
    checks_done++;
    if (g !== e) begin
      err_count++;
      $display("CHECK FAILED %s expected %h seen %h", n, e, g);
    end
  endtask
  task automatic axw(input logic [11:0] a, input logic [15:0] d, input logic [1:0] e);
    logic ta;
    logic tw;
    ta = 1'b0;
    tw = 1'b0;
    @(posedge clk);
    awaddr <= a;
    wdata <= {16'h0000, d};
    awv <= 1'b1;
    wv <= 1'b1;
    bready <= 1'b1;
    while (!(ta && tw)) begin
      @(posedge clk);
      if (awrdy === 1'b1) begin
        ta = 1'b1;
        awv <= 1'b0;
      end
      if (wrdy === 1'b1) begin
        tw = 1'b1;
        wv <= 1'b0;
      end
    end
    do @(posedge clk); while (bvalid !== 1'b1);
    bready <= 1'b0;
    chk("bresp", {30'h0, e}, {30'h0, bresp});
  endtask
  task automatic axr(input logic [11:0] a, input logic [15:0] e, input logic [1:0] er);
    @(posedge clk);
    araddr <= a;
    arv <= 1'b1;
    rready <= 1'b1;
    do @(posedge clk); while (arrdy !== 1'b1);
    arv <= 1'b0;
    do @(posedge clk); while (rvalid !== 1'b1);
    rready <= 1'b0;
    chk("rdata", {16'h0000, e}, rdata);
    chk("rresp", {30'h0, er}, {30'h0, rresp});
  endtask
  task automatic pulse(input int i, input logic [2:0] e);
    @(posedge clk);
    evt[i] <= 1'b1;
    @(posedge clk);
    evt[i] <= 1'b0;
    #1;
    chk("irq", {29'h0, e}, {29'h0, irq});
  endtask
  // settle two periods first, then a 64-cycle window spans whole periods exactly
  task automatic meas(input logic [15:0] eh, input logic [15:0] el);
    repeat (130) @(posedge clk);
    gate <= 1'b1;
    repeat (64) @(posedge clk);
    gate <= 1'b0;
    #1;
    chk("high_on", {16'h0, eh}, {16'h0, hcnt});
    chk("low_on", {16'h0, el}, {16'h0, lcnt});
  endtask
  task automatic t_regs;
    axr(RC, 16'h0000, OK);
    axr(RP, 16'h0000, OK);
    axr(RS, 16'h0000, OK);
    axw(12'h040, 16'h1234, `PWG_RESP_DECERR);
    axr(12'h040, 16'h0000, `PWG_RESP_DECERR);
    axw(RC, 16'hFFFF, OK);
    axr(RC, 16'h1FEF, OK);
    axw(RC, 16'h0000, OK);
  endtask
  task automatic t_events;
    for (int i = 0; i < 3; i++) begin
      axw(RC, 16'h0400 << i, OK);
      pulse(i, 3'h1 << i);
      axr(RC, 16'h2400 << i, OK);
      axw(RC, 16'h0000, OK);
      axr(RC, 16'h0000, OK);
      pulse(i, 3'h0);
      axr(RC, 16'h2000 << i, OK);
      axw(RC, 16'h0000, OK);
    end
  endtask
  task automatic t_duty;
    axw(RC, 16'h0081, OK);
    axw(RS, 16'h0020, OK);
    for (int i = 0; i < 3; i++) begin
      axw(RP, DV[i], OK);
      meas(HV[i], 16'h0020);
    end
  endtask
  task automatic t_modes;
    @(posedge clk);
    mode <= `PWG_MODE_COMPL;
    axw(RP, 16'h0010, OK);
    for (int i = 0; i < 6; i++) begin
      @(posedge clk);
      cin <= (i == 3);
      axw(RC, CW[i], OK);
      meas(CH[i], CL[i]);
    end
    @(posedge clk);
    shd <= 16'h0018;
    axw(RC, 16'h0181, OK);
    meas(16'h0018, 16'h0028);
    @(posedge clk);
    mode <= `PWG_MODE_REDUN;
    meas(16'h0018, 16'h0018);
  endtask
  task automatic t_sel;
    @(posedge clk);
    mode <= `PWG_MODE_INDEP;
    axw(RC, 16'h0085, OK);
    axw(RP, 16'h0013, OK);
    meas(16'h0013, 16'h0020);
    axw(RP, 16'h0010, OK);
    axw(RC, 16'h0089, OK);
    meas(16'h0020, 16'h0040);
    axw(`PWG_OFF_LPER, 16'h001F, OK);
    axw(RS, 16'h0008, OK);
    axw(RC, 16'h0281, OK);
    meas(16'h0020, 16'h0010);
    axw(RC, 16'h0283, OK);
    pulse(1, 3'h0);
    axr(`PWG_OFF_STAT, 16'h0001, OK);
  endtask
  task automatic end_of_test;
    if (err_count == 0 && checks_done > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask
  initial begin
    repeat (8) @(posedge clk);
    rst_n <= 1'b1;
    t_regs;
    t_events;
    t_duty;
    t_modes;
    t_sel;
    end_of_test;
  end
  // whole run is a few thousand cycles; this allows about twenty thousand
  initial begin
    #800000;
    err_count++;
    end_of_test;
  end
endmodule // tb_top
